//--- inc/corr_pkg.sv
// constants shared by the channel correlation and delay logic
// assumes one 50 MHz clock; a sample slot stands for one nanosecond of emulated time
package corr_pkg;
    // correlation modes
    typedef enum logic [1:0]
    {
        MODE_OFF     = 2'b00,
        MODE_REPLICA = 2'b01,
        MODE_TRIGGER = 2'b11,
        MODE_COMMON  = 2'b10
    } corr_mode_t;

    localparam int SAMPLE_W      = 16;    // dac word width
    localparam int STEP_NS       = 1;     // one buffer slot per nanosecond
    localparam int DELAY_MIN_NS  = 1;
    localparam int DELAY_MAX_NS  = 4000;
    localparam int DELAY_MIN     = DELAY_MIN_NS / STEP_NS;
    localparam int DELAY_MAX     = DELAY_MAX_NS / STEP_NS;
    localparam int BUF_DEPTH     = 4096;  // at least DELAY_MAX slots
    localparam int PTR_W         = $clog2(BUF_DEPTH);
    localparam int LVDS_FRAME    = 16;    // bits per serial word
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;
endpackage

//--- rtl/lvds_word_tx.sv
// serialises one 16-bit dac word per frame onto a differential pair
// assumes a new word is offered only when o_ready is high
module lvds_word_tx
    import corr_pkg::*;
#(
    parameter int W = SAMPLE_W
)
(
    // clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset_n,
    // word side
    input  wire logic [W-1:0] i_word,
    input  wire logic         i_load,
    output logic              o_ready,
    // serial side
    output logic              o_lvds_p,
    output logic              o_lvds_n,
    output logic              o_frame
);
    logic [W-1:0]         shreg_r, shreg_nxt;
    logic [$clog2(W):0]   cnt_r, cnt_nxt;
    logic                 bit_nxt, frame_nxt;

    // msb first, frame marks the first bit of each word
    always_comb
    begin
        shreg_nxt = shreg_r;
        cnt_nxt   = cnt_r;
        bit_nxt   = o_lvds_p;
        frame_nxt = 1'b0;
        if (cnt_r != '0)
        begin
            bit_nxt   = shreg_r[W-1];
            shreg_nxt = {shreg_r[W-2:0], 1'b0};
            cnt_nxt   = cnt_r - 1'b1;
        end
        else if (i_load)
        begin
            bit_nxt   = i_word[W-1];
            frame_nxt = 1'b1;
            shreg_nxt = {i_word[W-2:0], 1'b0};
            cnt_nxt   = ($clog2(W)+1)'(W - 1);
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            shreg_r  <= '0;
            cnt_r    <= '0;
            o_lvds_p <= 1'b0;
            o_lvds_n <= 1'b1;
            o_frame  <= 1'b0;
            o_ready  <= 1'b1;
        end
        else
        begin
            shreg_r  <= shreg_nxt;
            cnt_r    <= cnt_nxt;
            o_lvds_p <= bit_nxt;
            o_lvds_n <= ~bit_nxt;
            o_frame  <= frame_nxt;
            o_ready  <= (cnt_nxt == '0);
        end
    end
endmodule

//--- rtl/channel_correlation_delay.sv
// correlates the two emulator channels and ships both sample streams to their dacs
// assumes one sample per i_sample_valid, each sample standing for one nanosecond
// assumes the host changes i_mode and i_delay_ns only between bursts of samples
// the serial links move one bit per clock, so accepted samples lie eighteen cycles apart
// What this block does
// - in replica and trigger modes the master channel runs on its own event timing and the slave follows it by a set delay.
// - in replica mode the sample stream of the second dac comes from a DEPTH-slot circular buffer read the delay back.
// - each buffer position adds exactly one nanosecond of delay.
// - delays from one nanosecond to four microseconds in whole steps are accepted.
// - in replica mode the slave outputs the master's own event, shifted by the delay.
// - in trigger mode the slave uses its own samples and the master trigger arrives delayed.
// - in common mode a third channel's event is added identically to both outputs.
// - each channel goes to its own 16-bit dac over a separate lvds pair.
module channel_correlation_delay
    import corr_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
)
(
    // clock and reset
    input  wire logic                i_sys_clk,
    input  wire logic                i_reset_n,
    // configuration
    input  wire corr_pkg::corr_mode_t i_mode,
    input  wire logic [12:0]         i_delay_ns,
    // sample streams
    input  wire logic                i_sample_valid,
    input  wire logic [SAMPLE_W-1:0] i_master_sample,
    input  wire logic                i_master_trig,
    input  wire logic [SAMPLE_W-1:0] i_slave_sample,
    input  wire logic [SAMPLE_W-1:0] i_third_sample,
    // slave trigger and status
    output logic                     o_slave_trig,
    output logic                     o_delay_err,
    output logic                     o_stall,
    // dac links
    output logic                     o_dac0_p,
    output logic                     o_dac0_n,
    output logic                     o_dac0_frame,
    output logic                     o_dac1_p,
    output logic                     o_dac1_n,
    output logic                     o_dac1_frame
);
    import corr_pkg::*;

    localparam int PW = $clog2(DEPTH);
    // pointer arithmetic wraps at DEPTH, so DEPTH is meant to be a power of two;
    // a DEPTH below DELAY_MAX would alias long delays onto short ones

    // ring memory: sample plus trigger per slot
    logic [SAMPLE_W:0]       ring [DEPTH];
    logic [PW-1:0]           wr_ptr_r, wr_ptr_nxt;
    logic [PW-1:0]           dly_r, dly_nxt;
    logic                    err_nxt;
    logic [SAMPLE_W:0]       ring_rd;
    logic [SAMPLE_W-1:0]     dac0_r, dac0_nxt, dac1_r, dac1_nxt;
    logic                    trig_nxt, load_r, load_nxt;
    logic                    rdy0, rdy1;
    logic [SAMPLE_W-1:0]     ring_wr_sample;
    logic [SAMPLE_W-1:0]     delayed_sample;
    logic                    delayed_trig;
    logic [PW:0]             fill_r, fill_nxt;
    logic                    primed;

    // check the delay against the legal span; out-of-range values flag an error
    // an out-of-range request keeps the last good delay in force
    always_comb
    begin
        dly_nxt = dly_r;
        err_nxt = 1'b0;
        if (i_delay_ns < 13'(DELAY_MIN) || i_delay_ns > 13'(DELAY_MAX))
            err_nxt = 1'b1;
        else
            dly_nxt = PW'(i_delay_ns / 13'(STEP_NS));
    end

    // replica mode delays the master samples, otherwise the slave's own
    always_comb
    begin
        ring_wr_sample = (i_mode == MODE_REPLICA) ? i_master_sample : i_slave_sample;
    end

    // one slot per sample so the depth in slots is the delay in nanoseconds
    always_comb
    begin
        wr_ptr_nxt = wr_ptr_r;
        if (i_sample_valid && !o_stall)
            wr_ptr_nxt = wr_ptr_r + 1'b1;
    end

    // count accepted samples up to DEPTH so that slots never written read as
    // silence; without it the first outputs after reset would be unknown
    always_comb
    begin
        fill_nxt = fill_r;
        if (i_sample_valid && !o_stall && fill_r != (PW+1)'(DEPTH))
            fill_nxt = fill_r + 1'b1;
    end

    // the slot dly_r back holds data only once that many samples were taken
    assign primed = (fill_r >= {1'b0, dly_r});

    // store each accepted sample with its trigger; the ring has no reset, so
    // unwritten slots are masked by primed rather than cleared
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sample_valid && !o_stall)
        begin
            ring[wr_ptr_r] <= {i_master_trig, ring_wr_sample};
        end
    end

    // read the slot written dly_r accepted samples ago; the read is
    // combinational so the delayed word lines up with the current take
    assign ring_rd        = ring[PW'(wr_ptr_r - dly_r)];
    assign delayed_sample = primed ? ring_rd[SAMPLE_W-1:0] : SAMPLE_RST;
    assign delayed_trig   = primed & ring_rd[SAMPLE_W];

    // output mix per mode; in common mode the third channel adds into both paths alike
    always_comb
    begin
        dac0_nxt = dac0_r;
        dac1_nxt = dac1_r;
        trig_nxt = 1'b0;
        load_nxt = 1'b0;
        if (i_sample_valid && !o_stall)
        begin
            load_nxt = 1'b1;
            unique case (i_mode)
                MODE_OFF:
                begin
                    // channels run independently, no correlation
                    dac0_nxt = i_master_sample;
                    dac1_nxt = i_slave_sample;
                end
                MODE_REPLICA:
                begin
                    // the master word itself reaches the second dac after the delay
                    dac0_nxt = i_master_sample;
                    dac1_nxt = delayed_sample;
                end
                MODE_TRIGGER:
                begin
                    // only the trigger is delayed; both streams pass straight through
                    dac0_nxt = i_master_sample;
                    dac1_nxt = i_slave_sample;
                    trig_nxt = delayed_trig;
                end
                MODE_COMMON:
                begin
                    // sums wrap modulo 2^16; keeping amplitudes in range is left
                    // to the host, saturation would distort the shared event
                    dac0_nxt = SAMPLE_W'(i_master_sample + i_third_sample);
                    dac1_nxt = SAMPLE_W'(i_slave_sample + i_third_sample);
                end
            endcase
        end
    end

    // timing of one accepted sample, counted from the taking edge e0:
    //   after e0       load_r and o_stall high, o_slave_trig for one cycle
    //   after e1       both serialisers load, frame and bit 15 appear
    //   after e2..e16  bits 14 down to 0, one per cycle
    //   after e17      o_stall drops and the next sample may be offered
    // the serial rate, not the ring, sets how fast samples are accepted
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            wr_ptr_r     <= '0;
            fill_r       <= '0;
            dly_r        <= PW'(DELAY_MIN);
            o_delay_err  <= 1'b0;
            dac0_r       <= SAMPLE_RST;
            dac1_r       <= SAMPLE_RST;
            o_slave_trig <= 1'b0;
            load_r       <= 1'b0;
            o_stall      <= 1'b0;
        end
        else
        begin
            wr_ptr_r     <= wr_ptr_nxt;
            fill_r       <= fill_nxt;
            dly_r        <= dly_nxt;
            o_delay_err  <= err_nxt;
            dac0_r       <= dac0_nxt;
            dac1_r       <= dac1_nxt;
            o_slave_trig <= trig_nxt;
            load_r       <= load_nxt;
            // samples arriving while a word is still serialising are refused;
            // load_r covers the cycle before the serialisers drop ready, which
            // would otherwise let a second sample in and lose it
            o_stall      <= ~(rdy0 & rdy1) | load_nxt | load_r;
        end
    end

    // separate serial link per dac
    // both links share one load strobe so their frames stay aligned
    lvds_word_tx #(.W(SAMPLE_W)) u_tx0
    (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_word    (dac0_r),
        .i_load    (load_r),
        .o_ready   (rdy0),
        .o_lvds_p  (o_dac0_p),
        .o_lvds_n  (o_dac0_n),
        .o_frame   (o_dac0_frame)
    );

    lvds_word_tx #(.W(SAMPLE_W)) u_tx1
    (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_word    (dac1_r),
        .i_load    (load_r),
        .o_ready   (rdy1),
        .o_lvds_p  (o_dac1_p),
        .o_lvds_n  (o_dac1_n),
        .o_frame   (o_dac1_frame)
    );
endmodule

//--- verif/channel_correlation_delay_checker.sv
// port assertions for the correlation block
// assumes one clock and a synchronous low reset
module channel_correlation_delay_checker
    import corr_pkg::*;
(
    input wire logic                 i_sys_clk, i_reset_n, i_sample_valid, i_master_trig,
    input wire corr_pkg::corr_mode_t i_mode,
    input wire logic [12:0]          i_delay_ns,
    input wire logic [SAMPLE_W-1:0]  i_master_sample, i_slave_sample, i_third_sample,
    input wire logic                 o_slave_trig, o_delay_err, o_stall, o_dac0_p, o_dac0_n,
    input wire logic                 o_dac0_frame, o_dac1_p, o_dac1_n, o_dac1_frame
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic take;
    // a sample counts only when not stalled
    assign take = i_sample_valid && !o_stall;
    chk_stall_take: assert property (take |=> o_stall)
        else $error("stall missing after a take");
    chk_stall_hold: assert property ($rose(o_stall) |-> o_stall [*8])
        else $error("stall dropped early");
    chk_frame_lat: assert property (take |-> ##2 (o_dac0_frame && o_dac1_frame))
        else $error("frames not two cycles after take");
    chk_frame_gap: assert property (o_dac0_frame |=> !o_dac0_frame [*8])
        else $error("frame repeated inside a word");
    chk_dac0_pair: assert property (o_dac0_n == !o_dac0_p)
        else $error("dac0 pair not complementary");
    chk_dac1_pair: assert property (o_dac1_n == !o_dac1_p)
        else $error("dac1 pair not complementary");
    chk_trig_mode: assert property (o_slave_trig |-> $past(i_mode) == MODE_TRIGGER)
        else $error("slave trigger outside trigger mode");
    chk_trig_take: assert property (o_slave_trig |-> $past(take))
        else $error("slave trigger without a take");
    chk_err_range: assert property (o_delay_err == ($past(i_delay_ns) == 13'h0 ||
        $past(i_delay_ns) > 13'hFA0))
        else $error("delay error flag wrong");
    cover property (take && i_mode == MODE_REPLICA);
    cover property (o_slave_trig);
    cover property (o_delay_err);
endmodule

bind channel_correlation_delay channel_correlation_delay_checker u_chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_sample_valid(i_sample_valid),
    .i_master_trig(i_master_trig), .i_mode(i_mode), .i_delay_ns(i_delay_ns),
    .i_master_sample(i_master_sample), .i_slave_sample(i_slave_sample),
    .i_third_sample(i_third_sample), .o_slave_trig(o_slave_trig), .o_delay_err(o_delay_err),
    .o_stall(o_stall), .o_dac0_p(o_dac0_p), .o_dac0_n(o_dac0_n), .o_dac0_frame(o_dac0_frame),
    .o_dac1_p(o_dac1_p), .o_dac1_n(o_dac1_n), .o_dac1_frame(o_dac1_frame));

//--- verif/dac_rx_model.sv
// serial dac receiver: rebuilds each 16-bit word
// assumes frame marks the msb and bits come msb first
module dac_rx_model
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_p,
    input  wire logic        i_frame,
    output logic [15:0]      o_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt = 5'h10;
    // stop after 16 bits so idle line does not spoil the word
    always @(posedge i_sys_clk)
    begin
        if (i_frame || cnt < 5'h10)
        begin
            o_word <= i_frame ? {15'h0, i_p} : {o_word[14:0], i_p};
            cnt <= i_frame ? 5'h1 : cnt + 5'h1;
        end
    end
endmodule

//--- verif/channel_correlation_delay_tb.sv
// self-checking bench for the correlation block
// assumes two dac receiver models on the serial lines
module channel_correlation_delay_tb;
    import corr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, vld, mt, strg, derr, stall, p0, n0, f0, p1, n1, f1, trg;
    corr_mode_t  mode;
    logic [12:0] dly;
    logic [15:0] ms, ss, ts, w0, w1;
    int          miscompares, num_checks;
    channel_correlation_delay u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_mode(mode),
        .i_delay_ns(dly), .i_sample_valid(vld), .i_master_sample(ms), .i_master_trig(mt),
        .i_slave_sample(ss), .i_third_sample(ts), .o_slave_trig(strg), .o_delay_err(derr),
        .o_stall(stall), .o_dac0_p(p0), .o_dac0_n(n0), .o_dac0_frame(f0), .o_dac1_p(p1),
        .o_dac1_n(n1), .o_dac1_frame(f1));
    dac_rx_model u_rx0 (.i_sys_clk(clk), .i_p(p0), .i_frame(f0), .o_word(w0));
    dac_rx_model u_rx1 (.i_sys_clk(clk), .i_p(p1), .i_frame(f1), .o_word(w1));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one sample; trigger caught in the cycle after the take
    task automatic send(input logic [15:0] m, input logic t, input logic [15:0] h);
        int n;
        ms = m;
        ss = ~m;
        mt = t;
        ts = h;
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        trg = strg;
        for (n = 0; stall !== 1'b0 && n <= 40; n++)
        begin
            @(negedge clk);
        end
        // a stall that never clears counts as a mismatch; the run goes on to the verdict
        if (stall !== 1'b0)
            miscompares++;
        repeat (2) @(negedge clk);
    endtask
    // flag follows the legal delay range
    task automatic t_limits();
        logic [12:0] v[4];
        v = '{13'h0, 13'hFA1, 13'hFA0, 13'h1};
        foreach (v[i])
        begin
            dly = v[i];
            @(negedge clk);
            check({15'h0, derr}, {15'h0, i < 2});
        end
    endtask
    // slave word is the master word d samples back
    task automatic t_replica(input logic [12:0] pgm, input int d);
        logic [15:0] q[$];
        mode = MODE_REPLICA;
        dly = pgm;
        for (int k = 0; k < d + 3; k++)
        begin
            q.push_back(16'hA000 + 16'(k));
            send(q[k], 1'b0, 16'h0);
            check(w0, q[k]);
            check({15'h0, trg}, 16'h0);
            if (k >= d)
                check(w1, q[k - d]);
        end
    endtask
    // a master event comes back as a slave trigger two samples later
    task automatic t_trigger();
        mode = MODE_TRIGGER;
        dly = 13'h2;
        for (int k = 0; k < 5; k++)
        begin
            send(16'h0100, k == 0, 16'h0);
            check({15'h0, trg}, {15'h0, k == 2});
        end
    endtask
    initial
    begin
        {rst_n, vld, mt, ms, ss, ts, miscompares, num_checks} = '0;
        mode = MODE_OFF;
        dly = 13'h1;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        check({13'h0, stall, f0, n0}, 16'h1);
        // off mode: each dac carries its own channel
        send(16'h1234, 1'b0, 16'h0);
        check(w0, 16'h1234);
        check(w1, 16'hEDCB);
        t_limits();
        t_replica(13'h3, 3);
        // out of range: the last good delay stays
        t_replica(13'h0, 3);
        check({15'h0, derr}, 16'h1);
        t_trigger();
        // third channel event added, wrapping
        mode = MODE_COMMON;
        send(16'hFFF0, 1'b0, 16'h0025);
        check(w0, 16'h0015);
        check(w1, 16'h0034);
        print_verdict();
    end
endmodule
